// File: rtl/sec_system_exception_control.v
// System exception control: reset control bits, handler priorities, handler state register.
// Assumes one clock, an asynchronous active-low system (warm) reset that the reset
// controller raises in answer to the reset request, and a core on the same clock.
`include "sec_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module sec_system_exception_control
(
    input wire clk,
    input wire reset_n,
    input wire clk_en,
    input wire [31:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    input wire [31:0] hcs_set,
    input wire [31:0] hcs_clear,
    output reg [31:0] rdata,
    output reg irq,
    output reg system_reset_request,
    output reg clear_active_state,
    output reg local_system_reset,
    output reg big_endian,
    output reg [2:0] priority_group,
    output reg [31:0] fault_handler_priority,
    output reg [31:0] supervisor_call_priority_word,
    output reg [31:0] tick_and_service_priority_word,
    output reg [31:0] handler_control_state,
    output reg usage_fault_enable,
    output reg bus_fault_enable,
    output reg memmanage_fault_enable
);

    // Sticky event status and its mask.
    reg [`SEC_EVT_WIDTH-1:0] evt_status;
    reg [`SEC_EVT_WIDTH-1:0] evt_mask;

    wire sel_irc;
    wire sel_pri_fault;
    wire sel_pri_svc;
    wire sel_pri_tick;
    wire sel_hcs;
    wire sel_stat;
    wire sel_mask;
    wire irc_write;
    wire key_ok;
    wire do_sysreq;
    wire do_clract;
    wire do_locrst;
    wire bad_key;

    reg [31:0] next_hcs;
    reg [31:0] next_rdata;
    reg [`SEC_EVT_WIDTH-1:0] next_status;
    reg [`SEC_EVT_WIDTH-1:0] evt_raise;
    reg [31:0] next_fault_pri;
    reg [31:0] next_svc_pri;
    reg [31:0] next_tick_pri;

    // Keeps a software write to the implemented bits only.
    function [31:0] merge_masked;
        input [31:0] old_value;
        input [31:0] new_value;
        input [31:0] mask;
        begin
            merge_masked = (old_value & ~mask) | (new_value & mask);
        end
    endfunction

    assign sel_irc = (addr == `SEC_ADDR_IRC);
    assign sel_pri_fault = (addr == `SEC_ADDR_PRI_FAULT);
    assign sel_pri_svc = (addr == `SEC_ADDR_PRI_SVC);
    assign sel_pri_tick = (addr == `SEC_ADDR_PRI_TICK);
    assign sel_hcs = (addr == `SEC_ADDR_HCS);
    assign sel_stat = (addr == `SEC_ADDR_EVT_STAT);
    assign sel_mask = (addr == `SEC_ADDR_EVT_MASK);

    assign irc_write = wr && sel_irc;
    assign key_ok = (wdata[`SEC_KEY_MSB:`SEC_KEY_LSB] == `SEC_KEY_WRITE);
    assign bad_key = irc_write && !key_ok;
    assign do_sysreq = irc_write && key_ok && wdata[`SEC_BIT_SYSREQ];
    assign do_clract = irc_write && key_ok && wdata[`SEC_BIT_CLRACT];
    assign do_locrst = irc_write && key_ok && wdata[`SEC_BIT_LOCRST];

    // Handler state: software writes first, then a clear-active wipe, then core
    // updates. The core's set wins over any clear in the same cycle so that an
    // exception that becomes active in that cycle is not lost.
    always @*
    begin
        next_hcs = handler_control_state;
        if (wr && sel_hcs)
        begin
            next_hcs = merge_masked(handler_control_state, wdata, `SEC_HCS_MASK);
        end
        if (do_clract)
        begin
            next_hcs = next_hcs & ~`SEC_HCS_ACTIVE_MASK;
        end
        next_hcs = next_hcs & ~hcs_clear;
        next_hcs = (next_hcs | hcs_set) & `SEC_HCS_MASK;
    end

    // Event status: write one to clear, a new event wins over the clear.
    always @*
    begin
        evt_raise = `SEC_EVT_RESET;
        evt_raise[`SEC_EVT_SYSREQ] = do_sysreq;
        evt_raise[`SEC_EVT_CLRACT] = do_clract;
        evt_raise[`SEC_EVT_LOCRST] = do_locrst;
        evt_raise[`SEC_EVT_BADKEY] = bad_key;
        next_status = evt_status;
        if (wr && sel_stat)
        begin
            next_status = evt_status & ~wdata[`SEC_EVT_WIDTH-1:0];
        end
        next_status = next_status | evt_raise;
    end

    // Read mux; the self-clearing bits always read as zero.
    always @*
    begin
        next_rdata = 32'h00000000;
        if (sel_irc)
        begin
            next_rdata[`SEC_KEY_MSB:`SEC_KEY_LSB] = `SEC_KEY_READ;
            next_rdata[`SEC_BIT_ENDIAN] = big_endian;
            next_rdata[`SEC_GRP_MSB:`SEC_GRP_LSB] = priority_group;
            next_rdata[`SEC_BIT_SYSREQ] = system_reset_request;
        end
        else if (sel_pri_fault)
        begin
            next_rdata = fault_handler_priority;
        end
        else if (sel_pri_svc)
        begin
            next_rdata = supervisor_call_priority_word;
        end
        else if (sel_pri_tick)
        begin
            next_rdata = tick_and_service_priority_word;
        end
        else if (sel_hcs)
        begin
            next_rdata = handler_control_state;
        end
        else if (sel_stat)
        begin
            next_rdata[`SEC_EVT_WIDTH-1:0] = evt_status;
        end
        else if (sel_mask)
        begin
            next_rdata[`SEC_EVT_WIDTH-1:0] = evt_mask;
        end
    end

    // Priority words: only the three top bits of each implemented byte take a write.
    always @*
    begin
        next_fault_pri = fault_handler_priority;
        next_svc_pri = supervisor_call_priority_word;
        next_tick_pri = tick_and_service_priority_word;
        if (wr && sel_pri_fault)
        begin
            next_fault_pri = merge_masked(fault_handler_priority, wdata,
                `SEC_PRI_FAULT_MASK);
        end
        if (wr && sel_pri_svc)
        begin
            next_svc_pri = merge_masked(supervisor_call_priority_word, wdata,
                `SEC_PRI_SVC_MASK);
        end
        if (wr && sel_pri_tick)
        begin
            next_tick_pri = merge_masked(tick_and_service_priority_word, wdata,
                `SEC_PRI_TICK_MASK);
        end
    end

    // Read data stand for one cycle only, so software never sees a stale word.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rdata <= 32'h00000000;
            irq <= 1'b0;
        end
        else if (clk_en)
        begin
            rdata <= rd ? next_rdata : 32'h00000000;
            irq <= |(next_status & evt_mask);
        end
    end

    // The request bit only leaves one through the warm reset it caused; the reset
    // controller turns the output into that warm reset.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            system_reset_request <= 1'b0;
        end
        else if (clk_en)
        begin
            if (do_sysreq)
            begin
                system_reset_request <= 1'b1;
            end
        end
    end

    // One-cycle pulses; the bits themselves never store a one.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            clear_active_state <= 1'b0;
            local_system_reset <= 1'b0;
        end
        else if (clk_en)
        begin
            clear_active_state <= do_clract;
            local_system_reset <= do_locrst;
        end
    end

    // A wrong key also blocks the format and grouping fields.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            big_endian <= `SEC_ENDIAN_RESET;
            priority_group <= `SEC_GRP_RESET;
        end
        else if (clk_en)
        begin
            if (irc_write && key_ok)
            begin
                big_endian <= wdata[`SEC_BIT_ENDIAN];
                priority_group <= wdata[`SEC_GRP_MSB:`SEC_GRP_LSB];
            end
        end
    end

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            fault_handler_priority <= `SEC_PRI_RESET;
            supervisor_call_priority_word <= `SEC_PRI_RESET;
            tick_and_service_priority_word <= `SEC_PRI_RESET;
        end
        else if (clk_en)
        begin
            fault_handler_priority <= next_fault_pri;
            supervisor_call_priority_word <= next_svc_pri;
            tick_and_service_priority_word <= next_tick_pri;
        end
    end

    // The enables are separate flops so that they leave as plain register outputs.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            handler_control_state <= `SEC_HCS_RESET;
            usage_fault_enable <= 1'b0;
            bus_fault_enable <= 1'b0;
            memmanage_fault_enable <= 1'b0;
        end
        else if (clk_en)
        begin
            handler_control_state <= next_hcs;
            usage_fault_enable <= next_hcs[`SEC_BIT_USG_ENA];
            bus_fault_enable <= next_hcs[`SEC_BIT_BUS_ENA];
            memmanage_fault_enable <= next_hcs[`SEC_BIT_MEM_ENA];
        end
    end

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            evt_status <= `SEC_EVT_RESET;
            evt_mask <= `SEC_EVT_RESET;
        end
        else if (clk_en)
        begin
            evt_status <= next_status;
            if (wr && sel_mask)
            begin
                evt_mask <= wdata[`SEC_EVT_WIDTH-1:0];
            end
        end
    end

    // The stack is never touched here, which is why software must rebuild it.

endmodule // sec_system_exception_control

`default_nettype wire

// File: rtl/sec_consts.vh
// Constants for the system exception control block: offsets, fields, keys and reset values.
// Included by the design file; holds definitions only.
`ifndef SEC_CONSTS_VH
`define SEC_CONSTS_VH

// Byte addresses of the registers.
`define SEC_ADDR_IRC 32'hE000ED0C
`define SEC_ADDR_PRI_FAULT 32'hE000ED18
`define SEC_ADDR_PRI_SVC 32'hE000ED1C
`define SEC_ADDR_PRI_TICK 32'hE000ED20
`define SEC_ADDR_HCS 32'hE000ED24
`define SEC_ADDR_EVT_STAT 32'hE000ED40
`define SEC_ADDR_EVT_MASK 32'hE000ED44

// Interrupt and reset control fields.
`define SEC_KEY_MSB 31
`define SEC_KEY_LSB 16
`define SEC_KEY_WRITE 16'h05FA
`define SEC_KEY_READ 16'hFA05
`define SEC_BIT_ENDIAN 15
`define SEC_GRP_MSB 10
`define SEC_GRP_LSB 8
`define SEC_BIT_SYSREQ 2
`define SEC_BIT_CLRACT 1
`define SEC_BIT_LOCRST 0
`define SEC_ENDIAN_RESET 1'h0
`define SEC_GRP_RESET 3'h0

// Implemented priority bits: three per implemented byte, at the top of the byte.
`define SEC_PRI_FAULT_MASK 32'hE0E0E0E0
`define SEC_PRI_SVC_MASK 32'hE0000000
`define SEC_PRI_TICK_MASK 32'hE0E000E0
`define SEC_PRI_RESET 32'h00000000

// Handler control and state fields.
`define SEC_HCS_MASK 32'h0007FD8B
`define SEC_HCS_ACTIVE_MASK 32'h00000D8B
`define SEC_HCS_RESET 32'h00000000
`define SEC_BIT_USG_ENA 18
`define SEC_BIT_BUS_ENA 17
`define SEC_BIT_MEM_ENA 16

// Event status bits.
`define SEC_EVT_WIDTH 4
`define SEC_EVT_SYSREQ 0
`define SEC_EVT_CLRACT 1
`define SEC_EVT_LOCRST 2
`define SEC_EVT_BADKEY 3
`define SEC_EVT_RESET 4'h0

`endif

// File: testbench/sec_checker_props.sv
// Port assertions for the exception control block.
// Bound into the design; needs sec_consts.vh on the include path.
`include "sec_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module sec_checker (
    input wire clk,
    input wire reset_n,
    input wire clk_en,
    input wire [31:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    input wire [31:0] hcs_set,
    input wire [31:0] rdata,
    input wire system_reset_request,
    input wire clear_active_state,
    input wire local_system_reset,
    input wire big_endian,
    input wire [31:0] fault_handler_priority,
    input wire [31:0] handler_control_state
);
    wire ctl = clk_en && wr && addr == `SEC_ADDR_IRC;
    wire key = wdata[31:16] == `SEC_KEY_WRITE;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    AST_REQ: assert property (ctl && key && wdata[2] |=> system_reset_request)
        else $error("request not raised");
    AST_REQ_HOLD: assert property (system_reset_request |=> system_reset_request)
        else $error("request dropped before reset");
    AST_CLR: assert property ($past(clk_en) |-> clear_active_state == $past(ctl && key && wdata[1]))
        else $error("clear pulse wrong");
    AST_WIPE: assert property (ctl && key && wdata[1] |=>
        (handler_control_state & `SEC_HCS_ACTIVE_MASK & ~$past(hcs_set)) == 32'h0)
        else $error("active state kept");
    AST_LOC: assert property ($past(clk_en) |-> local_system_reset == $past(ctl && key && wdata[0]))
        else $error("local reset pulse wrong");
    AST_BADKEY: assert property (ctl && !key |=> $stable(big_endian) && $stable(system_reset_request)
        && !clear_active_state && !local_system_reset)
        else $error("wrong key took effect");
    AST_PRI_WR: assert property (clk_en && wr && addr == `SEC_ADDR_PRI_FAULT |=>
        fault_handler_priority == ($past(wdata) & `SEC_PRI_FAULT_MASK))
        else $error("priority write wrong");
    AST_PRI_ZERO: assert property ((fault_handler_priority & ~`SEC_PRI_FAULT_MASK) == 32'h0)
        else $error("unused priority bit set");
    AST_RD_KEY: assert property (clk_en && rd && addr == `SEC_ADDR_IRC |=> rdata[31:16] == `SEC_KEY_READ)
        else $error("key field read wrong");
endmodule // sec_checker
bind sec_system_exception_control sec_checker sec_checker_inst (.clk(clk), .reset_n(reset_n),
    .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .hcs_set(hcs_set),
    .rdata(rdata), .system_reset_request(system_reset_request),
    .clear_active_state(clear_active_state), .local_system_reset(local_system_reset),
    .big_endian(big_endian), .fault_handler_priority(fault_handler_priority),
    .handler_control_state(handler_control_state));
`default_nettype wire

// File: testbench/sec_core_model.sv
// Core and reset controller beside the block.
// Assumes the bench commands the handler state port.
`timescale 1ns/1ps
`default_nettype none
module sec_core_model (
    input wire logic clk,
    input wire logic por_n,
    input wire logic system_reset_request,
    input wire logic [31:0] set_cmd,
    input wire logic [31:0] clr_cmd,
    output logic reset_n,
    output logic [31:0] hcs_set,
    output logic [31:0] hcs_clear
);
    logic [1:0] warm;
    // The warm reset lasts three edges so the request is surely gone on release.
    always @(posedge clk or negedge por_n)
        if (!por_n)
            warm <= 2'h0;
        else if (system_reset_request)
            warm <= 2'h3;
        else if (warm != 2'h0)
            warm <= warm - 2'h1;
    assign reset_n = por_n && warm == 2'h0;
    assign hcs_set = set_cmd;
    assign hcs_clear = clr_cmd;
endmodule // sec_core_model
`default_nettype wire

// File: testbench/tb_top.sv
// Self-checking bench for the exception control block.
// Assumes the core model makes reset and drives the handler state port.
`include "sec_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 0, por_n = 0, clk_en = 1, wr = 0, rd = 0, pend = 0;
    logic [31:0] addr = 0, wdata = 0, set_cmd = 0, clr_cmd = 0;
    logic [31:0] pa [3] = '{`SEC_ADDR_PRI_FAULT, `SEC_ADDR_PRI_SVC, `SEC_ADDR_PRI_TICK};
    logic [31:0] pm [3] = '{`SEC_PRI_FAULT_MASK, `SEC_PRI_SVC_MASK, `SEC_PRI_TICK_MASK};
    logic [31:0] q [$];
    wire reset_n, irq, sreq, clr, lrst, be, ufe;
    wire [31:0] rdata, hs, hc;
    int n_fail = 0, total_checks = 0;
    always #4 clk = ~clk;
    sec_core_model sec_core_model_inst (.clk(clk), .por_n(por_n), .system_reset_request(sreq),
        .set_cmd(set_cmd), .clr_cmd(clr_cmd), .reset_n(reset_n), .hcs_set(hs), .hcs_clear(hc));
    sec_system_exception_control sec_system_exception_control_inst (.clk(clk),
        .reset_n(reset_n), .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .hcs_set(hs), .hcs_clear(hc), .rdata(rdata), .irq(irq), .system_reset_request(sreq),
        .clear_active_state(clr), .local_system_reset(lrst), .big_endian(be),
        .priority_group(), .fault_handler_priority(), .supervisor_call_priority_word(),
        .tick_and_service_priority_word(), .handler_control_state(),
        .usage_fault_enable(ufe), .bus_fault_enable(), .memmanage_fault_enable());
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr_t(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1;
        @(posedge clk);
        wr <= 0;
        #1;
    endtask
    task automatic rd_t(input logic [31:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1;
        q.push_back(e);
        @(posedge clk);
        rd <= 0;
        #1;
    endtask
    task automatic complete_run();
        $display("checks=%0d failures=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk)
    begin
        if (pend)
            chk(rdata, q.pop_front());
        pend <= rd;
    end
    initial
    begin
        repeat (3000) @(posedge clk);
        n_fail++;
        complete_run();
    end
    initial
    begin
        logic [31:0] r;
        r = $urandom(63899);
        repeat (6) @(posedge clk);
        por_n <= 1;
        rd_t(`SEC_ADDR_IRC, 32'hFA050000);
        rd_t(`SEC_ADDR_PRI_FAULT, 32'h0);
        rd_t(32'hE000ED30, 32'h0);
        for (int i = 0; i < 3; i++)
        begin
            r = $urandom;
            wr_t(pa[i], r);
            rd_t(pa[i], r & pm[i]);
        end
        wr_t(`SEC_ADDR_IRC, 32'h12348307);
        chk(32'(sreq | clr | lrst | irq), 32'h0);
        rd_t(`SEC_ADDR_IRC, 32'hFA050000);
        wr_t(`SEC_ADDR_EVT_MASK, 32'hF);
        rd_t(`SEC_ADDR_EVT_STAT, 32'h8);
        chk(32'(irq), 32'h1);
        wr_t(`SEC_ADDR_EVT_STAT, 32'h8);
        rd_t(`SEC_ADDR_EVT_STAT, 32'h0);
        chk(32'(irq), 32'h0);
        wr_t(`SEC_ADDR_IRC, 32'h05FA8300);
        rd_t(`SEC_ADDR_IRC, 32'hFA058300);
        set_cmd <= 32'hFFFFFFFF;
        @(posedge clk);
        set_cmd <= 32'h0;
        rd_t(`SEC_ADDR_HCS, `SEC_HCS_MASK);
        chk(32'(ufe), 32'h1);
        wr_t(`SEC_ADDR_IRC, 32'h05FA0002);
        chk(32'(clr), 32'h1);
        // Software must rebuild the stack here; neither the core model nor the block restores it.
        rd_t(`SEC_ADDR_HCS, 32'h0007F000);
        chk(32'(clr), 32'h0);
        wr_t(`SEC_ADDR_IRC, 32'h05FA0001);
        chk(32'(lrst), 32'h1);
        rd_t(`SEC_ADDR_EVT_STAT, 32'h6);
        wr_t(`SEC_ADDR_IRC, 32'h05FA0004);
        chk(32'(sreq), 32'h1);
        repeat (6) @(posedge clk);
        rd_t(`SEC_ADDR_IRC, 32'hFA050000);
        rd_t(`SEC_ADDR_PRI_FAULT, 32'h0);
        repeat (3) @(posedge clk);
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
